//--- design/fwdc_top.sv
// firmware download command checker: validates sub-commands, returns one status each
`timescale 1ns/1ns
module fwdc_top
(
   input  wire logic              ref_clk_i,      // 125 mhz clock
   input  wire logic              rst_n_i,        // synchronous reset, active low
   input  wire logic              cmd_valid_i,    // one-cycle sub-command strobe
   input  wire logic [1:0]        cmd_sub_i,      // sub-command code
   input  wire logic [3:0]        cmd_format_i,   // record encoding from options word
   input  wire logic              cmd_action_i,   // requested action: flash or memory
   input  wire logic              cmd_field_bad_i,// parameter block field plainly invalid
   input  wire logic [15:0]       pkt_seq_i,      // packet sequence number
   input  wire logic [15:0]       pkt_len_i,      // packet byte length
   input  wire logic [15:0]       pkt_crc_i,      // host supplied packet checksum
   input  wire logic [15:0]       pkt_calc_crc_i, // checksum computed over the packet
   input  wire logic [15:0]       xfer_pkts_i,    // expected packet total
   input  wire logic [31:0]       xfer_bytes_i,   // expected byte total, compared at finish
   input  wire logic [31:0]       tmo_value_i,    // command timeout value
   input  wire logic              hw_mem_ok_i,    // memory size sufficient
   input  wire logic              hw_nvm_fit_i,   // rewritable program memory fitted
   input  wire logic              xlate_err_i,    // record to image conversion failed
   input  wire logic              img_sum_ok_i,   // image internal checksum good
   input  wire logic              img_action_i,   // action the image is built for
   input  wire logic              prog_fail_i,    // nonvolatile programming failed
   output logic                   rsp_valid_o,    // one-cycle response strobe
   output logic [11:0]            rsp_status_o,   // return status word
   output logic [31:0]            tmo_cfg_o       // configured timeout, full width
);
   import fwdc_pkg::*;

   fwdc_state_t  state_ff;
   fwdc_state_t  nxt_state;
   logic [15:0]  seq_ff;
   logic [15:0]  pkts_ff;
   logic [31:0]  bytes_ff;
   logic [31:0]  tmo_cnt_ff;
   logic         tmo_run_ff;
   logic         rsp_valid_ff;
   logic [11:0]  rsp_status_ff;
   logic [31:0]  tmo_cfg_ff;
   logic [11:0]  setup_st;
   logic [11:0]  pkt_st;
   logic [11:0]  fin_st;
   logic [11:0]  status_w;
   logic         tmo_hit;
   logic         is_setup;
   logic         is_pkt;
   logic         is_fin;
   logic         is_tmo;
   logic [31:0]  bytes_sum;
   logic         setup_ok;

   // sub-command decode
   assign is_setup = cmd_valid_i && (cmd_sub_i == SUB_SETUP);
   assign is_pkt   = cmd_valid_i && (cmd_sub_i == SUB_PACKET);
   assign is_fin   = cmd_valid_i && (cmd_sub_i == SUB_FINISH);
   assign is_tmo   = cmd_valid_i && (cmd_sub_i == SUB_TIMEOUT);
   assign bytes_sum = bytes_ff + {16'h0000, pkt_len_i};
   // only an accepted setup may clear the totals; a refused one leaves a running download alone
   assign setup_ok = is_setup && (setup_st == ST_GOOD) && !tmo_hit;

   // setup checks, first failing check wins
   assign setup_st = (!hw_mem_ok_i || !hw_nvm_fit_i) ? ST_HW :
                     (cmd_format_i != FMT_SREC)      ? ST_FORMAT :
                     cmd_field_bad_i                 ? ST_PARAM :
                                                       ST_GOOD;

   // packet checks; a packet while idle is out of sequence unless its field is bad, one after completion gets the done status
   assign pkt_st = (state_ff == FWDC_DONE)   ? ST_DONE_PKT :
                   cmd_field_bad_i           ? ST_PARAM :
                   (state_ff != FWDC_LOAD)   ? ST_SEQ :
                   (pkt_seq_i != seq_ff)     ? ST_SEQ :
                   (pkt_calc_crc_i != pkt_crc_i) ? ST_CRC :
                                               ST_GOOD;

   // finish checks in the order the image is handled
   assign fin_st = (state_ff != FWDC_LOAD)     ? ST_PARAM :
                   xlate_err_i                 ? ST_XLATE :
                   (pkts_ff != xfer_pkts_i)    ? ST_PKT_CNT :
                   (bytes_ff != xfer_bytes_i)  ? ST_BYTE_CNT :
                   !img_sum_ok_i               ? ST_IMG_SUM :
                   (img_action_i != cmd_action_i) ? ST_IMG_TYPE :
                   prog_fail_i                 ? ST_PROG :
                                                 ST_GOOD;

   // timeout fires on full 32-bit compare, never truncated
   assign tmo_hit = tmo_run_ff && (tmo_cfg_ff != TMO_RESET)
                    && (tmo_cnt_ff >= tmo_cfg_ff);

   // timeout outranks the status of any same-cycle command; a same-cycle timeout value is still stored
   assign status_w = tmo_hit  ? ST_TIMEOUT :
                     is_setup ? setup_st :
                     is_pkt   ? pkt_st :
                     is_fin   ? fin_st :
                                ST_GOOD;

   // state advances only on a good status; a timeout or a failed finish in FWDC_LOAD returns to idle
   always_comb
   begin
      nxt_state = state_ff;
      case (state_ff)
         FWDC_IDLE: if (is_setup && setup_st == ST_GOOD && !tmo_hit) nxt_state = FWDC_LOAD;
         FWDC_LOAD:
         begin
            if (tmo_hit)
               nxt_state = FWDC_IDLE;
            else if (is_fin)
               nxt_state = (fin_st == ST_GOOD) ? FWDC_DONE : FWDC_IDLE;
         end
         FWDC_DONE: if (is_setup && setup_st == ST_GOOD && !tmo_hit) nxt_state = FWDC_LOAD;
         default:   nxt_state = FWDC_IDLE;
      endcase
   end

   // sequencer state
   always_ff @(posedge ref_clk_i)
   begin
      if (!rst_n_i)
         state_ff <= FWDC_IDLE;
      else
         state_ff <= nxt_state;
   end

   // packet and byte totals; reset by each accepted setup
   always_ff @(posedge ref_clk_i)
   begin
      if (!rst_n_i || setup_ok)
      begin
         seq_ff   <= SEQ_FIRST;
         pkts_ff  <= 16'h0000;
         bytes_ff <= 32'h0000_0000;
      end
      else if (is_pkt && pkt_st == ST_GOOD && !tmo_hit)
      begin
         seq_ff   <= seq_ff + 16'h0001;
         pkts_ff  <= pkts_ff + 16'h0001;
         bytes_ff <= bytes_sum;
      end
   end

   // timeout value stored at full width and echoed unaltered
   always_ff @(posedge ref_clk_i)
   begin
      if (!rst_n_i)
         tmo_cfg_ff <= TMO_RESET;
      else if (is_tmo)
         tmo_cfg_ff <= tmo_value_i;
   end

   // timer runs while a download is open; any command restarts it
   always_ff @(posedge ref_clk_i)
   begin
      if (!rst_n_i || cmd_valid_i || tmo_hit)
         tmo_cnt_ff <= 32'h0000_0000;
      else if (tmo_run_ff && tmo_cnt_ff != 32'hffff_ffff)
         tmo_cnt_ff <= tmo_cnt_ff + 32'h0000_0001;
   end

   always_ff @(posedge ref_clk_i)
   begin
      if (!rst_n_i)
         tmo_run_ff <= 1'b0;
      else
         tmo_run_ff <= (nxt_state == FWDC_LOAD);
   end

   // response: one status per command or per timeout
   always_ff @(posedge ref_clk_i)
   begin
      if (!rst_n_i)
      begin
         rsp_valid_ff  <= 1'b0;
         rsp_status_ff <= ST_GOOD;
      end
      else
      begin
         rsp_valid_ff  <= cmd_valid_i || tmo_hit;
         rsp_status_ff <= status_w;
      end
   end

   assign rsp_valid_o  = rsp_valid_ff;
   assign rsp_status_o = rsp_status_ff;
   assign tmo_cfg_o    = tmo_cfg_ff;

   // checks
   a_hw_status: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
      (is_setup && !tmo_hit && (!hw_mem_ok_i || !hw_nvm_fit_i))
      |=> (rsp_valid_o && rsp_status_o == ST_HW))
      else $error("hardware fault not reported as 0x90");
   a_format_status: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
      (is_setup && !tmo_hit && hw_mem_ok_i && hw_nvm_fit_i && cmd_format_i != FMT_SREC)
      |=> rsp_status_o == ST_FORMAT)
      else $error("bad format not reported as 0x91");
   a_done_packet: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
      (is_pkt && !tmo_hit && state_ff == FWDC_DONE) |=> rsp_status_o == ST_DONE_PKT)
      else $error("packet after completion not 0x94");
   a_seq_check: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
      (is_pkt && !tmo_hit && state_ff == FWDC_LOAD && !cmd_field_bad_i && pkt_seq_i != seq_ff)
      |=> (rsp_status_o == ST_SEQ && $stable(seq_ff)))
      else $error("out of order packet not 0x95");
   a_crc_check: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
      (is_pkt && !tmo_hit && state_ff == FWDC_LOAD && !cmd_field_bad_i
       && pkt_seq_i == seq_ff && pkt_calc_crc_i != pkt_crc_i) |=> rsp_status_o == ST_CRC)
      else $error("checksum mismatch not 0x96");
   a_pkt_count: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
      (is_fin && !tmo_hit && state_ff == FWDC_LOAD && !xlate_err_i && pkts_ff != xfer_pkts_i)
      |=> (rsp_status_o == ST_PKT_CNT && state_ff == FWDC_IDLE))
      else $error("packet count mismatch not 0x99");
   a_seq_advance: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
      (is_pkt && !tmo_hit && pkt_st == ST_GOOD)
      |=> (seq_ff == $past(seq_ff) + 16'h0001 && bytes_ff == $past(bytes_sum)))
      else $error("packet totals not advanced");
   a_timeout_code: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
      tmo_hit |=> (rsp_valid_o && rsp_status_o == ST_TIMEOUT && state_ff == FWDC_IDLE))
      else $error("timeout not reported as 0xc1");
   a_tmo_width: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
      is_tmo |=> tmo_cfg_o == $past(tmo_value_i))
      else $error("timeout value altered");
   a_one_status: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
      rsp_valid_o == ($past(cmd_valid_i) || $past(tmo_hit)))
      else $error("response without a cause");

   c_good_setup: cover property (@(posedge ref_clk_i) disable iff (!rst_n_i)
      is_setup && nxt_state == FWDC_LOAD);
   c_good_finish: cover property (@(posedge ref_clk_i) disable iff (!rst_n_i)
      is_fin && fin_st == ST_GOOD && !tmo_hit);
   c_timeout: cover property (@(posedge ref_clk_i) disable iff (!rst_n_i) tmo_hit);
   c_crc_fail: cover property (@(posedge ref_clk_i) disable iff (!rst_n_i)
      is_pkt && pkt_st == ST_CRC);
endmodule

//--- design/fwdc_pkg.sv
// package of constants for the firmware download checker
package fwdc_pkg;
   localparam logic [11:0] ST_GOOD      = 12'h000;
   localparam logic [11:0] ST_HW        = 12'h090;
   localparam logic [11:0] ST_FORMAT    = 12'h091;
   localparam logic [11:0] ST_PARAM     = 12'h092;
   localparam logic [11:0] ST_DONE_PKT  = 12'h094;
   localparam logic [11:0] ST_SEQ       = 12'h095;
   localparam logic [11:0] ST_CRC       = 12'h096;
   localparam logic [11:0] ST_XLATE     = 12'h097;
   localparam logic [11:0] ST_PKT_CNT   = 12'h099;
   localparam logic [11:0] ST_BYTE_CNT  = 12'h09a;
   localparam logic [11:0] ST_IMG_SUM   = 12'h09b;
   localparam logic [11:0] ST_IMG_TYPE  = 12'h09c;
   localparam logic [11:0] ST_PROG      = 12'h09d;
   localparam logic [11:0] ST_TIMEOUT   = 12'h0c1;
   // encodings of the option, action and sub-command fields, first sequence number and timeout reset value
   localparam logic [3:0]  FMT_SREC     = 4'h1;
   localparam logic [1:0]  SUB_SETUP    = 2'h0;
   localparam logic [1:0]  SUB_PACKET   = 2'h1;
   localparam logic [1:0]  SUB_FINISH   = 2'h2;
   localparam logic [1:0]  SUB_TIMEOUT  = 2'h3;
   localparam logic        ACT_FLASH    = 1'b0;
   localparam logic        ACT_MEMORY   = 1'b1;
   localparam logic [15:0] SEQ_FIRST    = 16'h0001;
   localparam logic [31:0] TMO_RESET    = 32'h0000_0000;
   typedef enum logic [1:0]
   {
      FWDC_IDLE = 2'b00,
      FWDC_LOAD = 2'b01,
      FWDC_DONE = 2'b10
   } fwdc_state_t;
endpackage

//--- testbench/fwdc_host_model.sv
// host model that issues firmware download sub-commands
`timescale 1ns/1ns
module fwdc_host_model
(
   input  wire logic        ref_clk_i,  // checker clock
   output logic             valid_o,    // sub-command strobe
   output logic [1:0]       sub_o,      // sub-command code
   output logic [3:0]       fmt_o,      // record encoding
   output logic             act_o,      // requested action
   output logic             bad_o,      // invalid field flag
   output logic [15:0]      seq_o,      // packet number
   output logic [15:0]      crc_o,      // host checksum
   output logic [15:0]      calc_o,     // checksum over packet
   output logic [15:0]      pkts_o,     // expected packets
   output logic [31:0]      val_o       // byte total or timeout
);
   import fwdc_pkg::*;
   // quiet bus before the first command
   initial
   begin
      {valid_o, sub_o, fmt_o, act_o, bad_o, seq_o, crc_o, calc_o, pkts_o, val_o} = '0;
   end
   // fields flip to their inverse once released, so stale values never look valid
   task automatic issue(input logic [1:0] s, input logic [3:0] f, input logic a,
                        input logic b, input logic [15:0] q, input logic ok,
                        input logic [15:0] p, input logic [31:0] v);
      @(posedge ref_clk_i);
      valid_o <= 1'b1;
      {sub_o, fmt_o, act_o, bad_o, pkts_o, val_o} <= {s, f, a, b, p, v};
      seq_o <= q;
      crc_o <= q ^ 16'h5a5a;
      calc_o <= ok ? q ^ 16'h5a5a : q ^ 16'h0f0f;
      @(posedge ref_clk_i);
      valid_o <= 1'b0;
      {sub_o, fmt_o, act_o, bad_o, seq_o, crc_o, calc_o, pkts_o, val_o} <=
         ~{sub_o, fmt_o, act_o, bad_o, seq_o, crc_o, calc_o, pkts_o, val_o};
   endtask
endmodule

//--- testbench/fwdc_top_tb.sv
// self-checking bench for the firmware download checker
`timescale 1ns/1ns
module fwdc_top_tb;
   import fwdc_pkg::*;
   logic        ref_clk_i, rst_n_i, rsp_valid_o;
   logic        mem_ok, nvm_fit, xlate_err, sum_ok, img_act, prog_fail;
   logic        c_valid, c_act, c_bad;
   logic [1:0]  c_sub;
   logic [3:0]  c_fmt;
   logic [15:0] c_seq, c_crc, c_calc, c_pkts;
   logic [31:0] c_val, tmo_cfg_o;
   logic [11:0] rsp_status_o;
   int          bad_count = 0;
   int          tests_run = 0;

   fwdc_host_model fwdc_host_model_inst (.ref_clk_i(ref_clk_i), .valid_o(c_valid),
      .sub_o(c_sub), .fmt_o(c_fmt), .act_o(c_act), .bad_o(c_bad), .seq_o(c_seq),
      .crc_o(c_crc), .calc_o(c_calc), .pkts_o(c_pkts), .val_o(c_val));
   fwdc_top fwdc_top_inst (.ref_clk_i(ref_clk_i), .rst_n_i(rst_n_i), .cmd_valid_i(c_valid),
      .cmd_sub_i(c_sub), .cmd_format_i(c_fmt), .cmd_action_i(c_act),
      .cmd_field_bad_i(c_bad), .pkt_seq_i(c_seq), .pkt_len_i(c_val[15:0]), .pkt_crc_i(c_crc),
      .pkt_calc_crc_i(c_calc), .xfer_pkts_i(c_pkts), .xfer_bytes_i(c_val),
      .tmo_value_i(c_val), .hw_mem_ok_i(mem_ok), .hw_nvm_fit_i(nvm_fit),
      .xlate_err_i(xlate_err), .img_sum_ok_i(sum_ok), .img_action_i(img_act),
      .prog_fail_i(prog_fail), .rsp_valid_o(rsp_valid_o), .rsp_status_o(rsp_status_o),
      .tmo_cfg_o(tmo_cfg_o));

   initial
   begin
      ref_clk_i = 1'b0;
      forever #4 ref_clk_i = ~ref_clk_i;
   end

   task automatic print_verdict;
      $display("tests_run=%0d bad_count=%0d", tests_run, bad_count);
      if (bad_count == 0 && tests_run > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask
   // the answer must be a strobe in this very cycle
   task automatic chk_rsp(input logic [11:0] exp);
      tests_run++;
      if (rsp_valid_o !== 1'b1 || rsp_status_o !== exp)
      begin
         bad_count++;
         $display("CHECK FAILED rsp_status expected %h seen %h", exp, rsp_status_o);
      end
   endtask
   task automatic chk_word(input string nm, input logic [31:0] exp, input logic [31:0] got);
      tests_run++;
      if (got !== exp)
      begin
         bad_count++;
         $display("CHECK FAILED %s expected %h seen %h", nm, exp, got);
      end
   endtask
   // issue one command; the answer registers on the taking edge, so look just after it
   task automatic cmd(input logic [1:0] s, input logic [3:0] f, input logic a, input logic b,
                      input logic [15:0] q, input logic ok, input logic [15:0] p,
                      input logic [31:0] v);
      fwdc_host_model_inst.issue(s, f, a, b, q, ok, p, v);
      #1;
   endtask
   task automatic setup(input logic [3:0] f, input logic b);
      cmd(SUB_SETUP, f, 1'b0, b, 16'h0, 1'b1, 16'h0, 32'h20);
   endtask
   task automatic pkt(input logic [15:0] q, input logic ok, input logic b);
      cmd(SUB_PACKET, FMT_SREC, 1'b0, b, q, ok, 16'h0, 32'h0000_0010);
   endtask
   task automatic fin(input logic a, input logic [15:0] p, input logic [31:0] v);
      cmd(SUB_FINISH, FMT_SREC, a, 1'b0, 16'h0, 1'b1, p, v);
   endtask
   // environment levels: mem, nvm, xlate error, sum ok, image action, program fail
   task automatic env(input logic [5:0] e);
      @(posedge ref_clk_i);
      {mem_ok, nvm_fit, xlate_err, sum_ok, img_act, prog_fail} <= e;
   endtask

   task automatic t_packet;
      fin(ACT_FLASH, 16'h0, 32'h0);
      chk_rsp(ST_PARAM);
      pkt(16'h1, 1'b1, 1'b0);
      chk_rsp(ST_SEQ);
      setup(FMT_SREC, 1'b0);
      chk_rsp(ST_GOOD);
      pkt(16'h1, 1'b1, 1'b0);
      chk_rsp(ST_GOOD);
      pkt(16'h3, 1'b1, 1'b0);
      chk_rsp(ST_SEQ);
      setup(FMT_SREC, 1'b0);
      chk_rsp(ST_GOOD);
      pkt(16'h1, 1'b0, 1'b0);
      chk_rsp(ST_CRC);
      setup(FMT_SREC, 1'b0);
      pkt(16'h1, 1'b0, 1'b1);
      chk_rsp(ST_PARAM);
      $display("test packet done");
   endtask
   task automatic t_setup;
      env(6'b010100);
      setup(4'h2, 1'b1);
      chk_rsp(ST_HW);
      env(6'b100100);
      setup(FMT_SREC, 1'b0);
      chk_rsp(ST_HW);
      env(6'b110100);
      setup(4'hf, 1'b1);
      chk_rsp(ST_FORMAT);
      setup(FMT_SREC, 1'b1);
      chk_rsp(ST_PARAM);
      $display("test setup done");
   endtask
   // one finish fault per pass after the first, which stacks three, both actions, with success last
   task automatic t_finish;
      logic [11:0] exp_tab [8];
      logic        a;
      exp_tab = '{ST_XLATE, ST_PKT_CNT, ST_BYTE_CNT, ST_IMG_SUM, ST_IMG_TYPE, ST_PROG,
                  ST_GOOD, ST_GOOD};
      for (int k = 0; k < 8; k++)
      begin
         a = k[0];
         env({2'b11, k == 0, k != 3 && k != 0, a ^ (k == 4), k == 5 || k == 0});
         setup(FMT_SREC, 1'b0);
         pkt(16'h1, 1'b1, 1'b0);
         pkt(16'h2, 1'b1, 1'b0);
         chk_rsp(ST_GOOD);
         fin(a, (k == 1) ? 16'h3 : 16'h2, (k == 2) ? 32'h21 : 32'h20);
         chk_rsp(exp_tab[k]);
      end
      pkt(16'h3, 1'b1, 1'b0);
      chk_rsp(ST_DONE_PKT);
      $display("test finish done");
   endtask
   // a wide timeout must run its full count, not a truncated one
   task automatic t_timeout;
      int n;
      cmd(SUB_TIMEOUT, FMT_SREC, 1'b0, 1'b0, 16'h0, 1'b1, 16'h0, 32'h0000_2005);
      chk_rsp(ST_GOOD);
      chk_word("tmo_cfg", 32'h0000_2005, tmo_cfg_o);
      setup(FMT_SREC, 1'b0);
      chk_rsp(ST_GOOD);
      // step past the setup answer before waiting for the timeout strobe
      n = 0;
      do
      begin
         @(posedge ref_clk_i);
         #1;
         n++;
      end
      while (rsp_valid_o !== 1'b1 && n < 9000);
      chk_rsp(ST_TIMEOUT);
      chk_word("tmo_wait", 32'h1, {31'h0, n > 8190 && n < 8200});
      $display("test timeout done");
   endtask

   initial
   begin
      repeat (20000) @(posedge ref_clk_i);
      bad_count++;
      print_verdict();
   end
   initial
   begin
      rst_n_i = 1'b0;
      {mem_ok, nvm_fit, xlate_err, sum_ok, img_act, prog_fail} = 6'b110100;
      repeat (2) @(posedge ref_clk_i);
      rst_n_i <= 1'b1;
      t_packet();
      t_setup();
      t_finish();
      t_timeout();
      print_verdict();
   end
endmodule
